// file: logic/thtrip_pkg.sv
/*
 * Constants for the thermal limit and shutdown trip logic: register indices,
 * reset values, zone bit positions and comparison constants.
 * Assumes a 32-bit classic Wishbone slave where the byte address is four times the index.
 */
package thtrip_pkg;

	localparam int           THT_ZONES       = 3;
	localparam int           THT_ADR_W       = 10;
	localparam int           THT_DAT_W       = 32;
	localparam int           THT_CNT_W       = 2;

	// Zone bit positions in the status and enable registers.
	localparam int           THT_BIT_AMBIENT = 0;
	localparam int           THT_BIT_DIODE1  = 1;
	localparam int           THT_BIT_DIODE2  = 2;

	// Register indices, listed per zone bit: ambient, remote diode 1, remote diode 2.
	localparam logic [7:0]   THT_ABS_IDX [THT_ZONES] = '{8'h6B, 8'h6A, 8'h6C};
	localparam logic [7:0]   THT_TRIP_IDX [THT_ZONES] = '{8'hC9, 8'hC4, 8'hC5};
	localparam logic [7:0]   THT_STAT_IDX    = 8'hCA;
	localparam logic [7:0]   THT_EN_IDX      = 8'hCB;

	localparam logic [7:0]   THT_ABS_RST     = 8'h64;
	localparam logic [7:0]   THT_TRIP_RST    = 8'h7F;
	localparam logic [2:0]   THT_STAT_RST    = 3'h0;
	localparam logic [2:0]   THT_EN_RST      = 3'h0;

	// An absolute limit of this value switches the full-fan override off for its zone.
	localparam logic [7:0]   THT_ABS_OFF     = 8'h80;

	// Successive monitoring cycles above the trip limit before the trip event fires.
	localparam logic [1:0]   THT_TRIP_CYCLES = 2'h2;

endpackage

// file: logic/thtrip_sync.sv
/*
 * Three-stage synchroniser for a level from outside the clock domain.
 * The output follows only once the second and third stages agree.
 * Assumes the input is a slow level such as a supply power-good pin.
 */
`timescale 1ns/1ps

module thtrip_sync (
	input  wire logic clk_i,   // System clock.
	input  wire logic rst_i,   // Synchronous reset, active high.
	input  wire logic ce_i,    // Clock enable.
	input  wire logic async_i, // Asynchronous level.
	output logic      level_o  // Filtered, synchronised level.
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	logic lvl_next;

	always_comb begin
		lvl_next = lvl_reg;
		if (s2_reg == s3_reg) begin
			lvl_next = s3_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else if (ce_i) begin
			s1_reg  <= async_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_o = lvl_reg;

endmodule // thtrip_sync

// file: logic/thtrip_top.sv
/*
 * Thermal protection of a hardware monitor: per-zone absolute limits that, in auto fan mode, force the enabled fan
 * PWM outputs to full duty, and per-zone shutdown trip limits with sticky status and an
 * active-low trip output. Registers sit behind a classic Wishbone slave.
 * Assumes zone readings, the cycle strobe, lock, auto-fan and PWM-disable come from
 * logic on the same clock; the supply power-good pin is asynchronous.
 */
`timescale 1ns/1ps

// Functional notes
// - With lock set, writes to absolute, trip limit and enable registers are ignored.
// - In auto fan mode, any zone above absolute limit forces enabled PWMs full.
// - Override also forces manual-mode fans; any zone triggers it, with or without fans.
// - Absolute limit 80h disables the override for that zone regardless of reading.
// - Limits are signed two's-complement whole degrees Celsius.
// - Each zone has its own trip limit, separate from interrupt high limit.
// - Zone above trip limit sets its status bit, whatever the output enable.
// - Status and output act only after two successive cycles above the limit.
// - Active-low trip output asserts for a zone only if its enable bit is 1.
// - Status and enable: bit 0 ambient, bit 1 diode 1, bit 2 diode 2.
// - A set status bit stays set until software writes 1 to it or supply power-good rises.
// - Writing 1 clears a status bit only when the zone's event is inactive.
// - Status returns to 00h on a rising edge of supply power-good, except bits whose event is live.
module thtrip_top #(
	parameter int NUM_PWM = 3
) (
	input  wire logic                            clk_i,                 // System clock, 25 MHz.
	input  wire logic                            rst_i,                 // Synchronous reset, active high.
	input  wire logic                            ce_i,                  // Clock enable; low freezes all state.
	input  wire logic                            wb_cyc_i,              // Wishbone cycle.
	input  wire logic                            wb_stb_i,              // Wishbone strobe.
	input  wire logic                            wb_we_i,               // Wishbone write enable.
	input  wire logic [thtrip_pkg::THT_ADR_W-1:0] wb_adr_i,             // Wishbone byte address.
	input  wire logic [3:0]                      wb_sel_i,              // Wishbone byte selects.
	input  wire logic [thtrip_pkg::THT_DAT_W-1:0] wb_dat_i,             // Wishbone write data.
	output logic      [thtrip_pkg::THT_DAT_W-1:0] wb_dat_o,             // Wishbone read data.
	output logic                                 wb_ack_o,              // Wishbone acknowledge.
	input  wire logic [7:0]                      ambient_temp_i,        // Ambient zone reading.
	input  wire logic [7:0]                      diode1_temp_i,         // Remote diode 1 reading.
	input  wire logic [7:0]                      diode2_temp_i,         // Remote diode 2 reading.
	input  wire logic                            cycle_strobe_i,        // Monitoring cycle done pulse.
	input  wire logic                            lock_i,                // Monitor lock bit.
	input  wire logic                            auto_fan_i,            // Some fan is in auto mode.
	input  wire logic [NUM_PWM-1:0]              pwm_disable_i,         // PWM outputs disabled.
	input  wire logic                            supply_power_good_i,   // Asynchronous power-good pin.
	output logic      [NUM_PWM-1:0]              pwm_full_o,            // Force PWM to 100% duty.
	output logic                                 shutdown_trip_out_n_o  // Trip output, active low.
);

	import thtrip_pkg::*;

	logic [THT_ZONES-1:0][7:0]          temp;
	logic [THT_ZONES-1:0][7:0]          abs_reg;
	logic [THT_ZONES-1:0][7:0]          abs_next;
	logic [THT_ZONES-1:0][7:0]          trip_lim_reg;
	logic [THT_ZONES-1:0][7:0]          trip_lim_next;
	logic [THT_ZONES-1:0][THT_CNT_W-1:0] cnt_reg;
	logic [THT_ZONES-1:0][THT_CNT_W-1:0] cnt_next;
	logic [THT_ZONES-1:0]               exceed_trip;
	logic [THT_ZONES-1:0]               ovr_zone;
	logic [THT_ZONES-1:0]               trip_event;
	logic [2:0]                         status_reg;
	logic [2:0]                         status_next;
	logic [2:0]                         en_reg;
	logic [2:0]                         en_next;
	logic [2:0]                         clr_req;
	logic                               ack_reg;
	logic                               ack_next;
	logic [THT_DAT_W-1:0]               dat_reg;
	logic [THT_DAT_W-1:0]               dat_next;
	logic [NUM_PWM-1:0]                 full_reg;
	logic [NUM_PWM-1:0]                 full_next;
	logic                               trip_n_reg;
	logic                               trip_n_next;
	logic                               pg_lvl;
	logic                               pg_prev_reg;
	logic                               pg_rise;
	logic                               req;
	logic                               wr;
	logic [7:0]                         idx;

	assign temp[THT_BIT_AMBIENT] = ambient_temp_i;
	assign temp[THT_BIT_DIODE1]  = diode1_temp_i;
	assign temp[THT_BIT_DIODE2]  = diode2_temp_i;

	// Only the first cycle of a request is served; the ack holds off a second write.
	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr  = req & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[THT_ADR_W-1:2];

	thtrip_sync u_pg_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i (supply_power_good_i),
		.level_o (pg_lvl)
	);

	assign pg_rise = pg_lvl & ~pg_prev_reg;

	genvar z;
	generate
		for (z = 0; z < THT_ZONES; z++) begin : g_zone
			// Signed compare, strictly greater: a reading equal to the limit is safe.
			assign exceed_trip[z] = $signed(temp[z]) > $signed(trip_lim_reg[z]);
			assign ovr_zone[z]    = (abs_reg[z] != THT_ABS_OFF) &&
				($signed(temp[z]) > $signed(abs_reg[z]));
			assign trip_event[z]  = (cnt_reg[z] == THT_TRIP_CYCLES);

			always_comb begin
				abs_next[z]      = abs_reg[z];
				trip_lim_next[z] = trip_lim_reg[z];
				cnt_next[z]      = cnt_reg[z];
				if (wr && !lock_i && idx == THT_ABS_IDX[z]) begin
					abs_next[z] = wb_dat_i[7:0];
				end
				if (wr && !lock_i && idx == THT_TRIP_IDX[z]) begin
					trip_lim_next[z] = wb_dat_i[7:0];
				end
				// Count successive cycles above the limit; one cycle at or below restarts it.
				if (cycle_strobe_i) begin
					if (!exceed_trip[z]) begin
						cnt_next[z] = '0;
					end else if (cnt_reg[z] != THT_TRIP_CYCLES) begin
						cnt_next[z] = cnt_reg[z] + 2'h1;
					end
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					abs_reg[z]      <= THT_ABS_RST;
					trip_lim_reg[z] <= THT_TRIP_RST;
					cnt_reg[z]      <= '0;
				end else if (ce_i) begin
					abs_reg[z]      <= abs_next[z];
					trip_lim_reg[z] <= trip_lim_next[z];
					cnt_reg[z]      <= cnt_next[z];
				end
			end
		end
	endgenerate

	// Status, enable and the trip pin.
	always_comb begin
		clr_req = '0;
		en_next = en_reg;
		if (wr && idx == THT_STAT_IDX) begin
			clr_req = wb_dat_i[2:0];
		end
		if (wr && !lock_i && idx == THT_EN_IDX) begin
			en_next = wb_dat_i[2:0];
		end
		// A live event overrides both the write-one clear and the power-good clear.
		status_next = pg_rise ? THT_STAT_RST : (status_reg & ~(clr_req & ~trip_event));
		status_next = status_next | trip_event;
		trip_n_next = ~|(trip_event & en_reg);
	end

	// Full-fan override: any zone may trigger it and every enabled PWM obeys, manual or not.
	always_comb begin
		full_next = '0;
		if (auto_fan_i && |ovr_zone) begin
			full_next = ~pwm_disable_i;
		end
	end

	// Wishbone answer: ack and read data one cycle after the request is seen.
	always_comb begin
		ack_next = req;
		dat_next = '0;
		if (req && !wb_we_i) begin
			for (int i = 0; i < THT_ZONES; i++) begin
				if (idx == THT_ABS_IDX[i]) begin
					dat_next[7:0] = abs_reg[i];
				end
				if (idx == THT_TRIP_IDX[i]) begin
					dat_next[7:0] = trip_lim_reg[i];
				end
			end
			if (idx == THT_STAT_IDX) begin
				dat_next[2:0] = status_reg;
			end
			if (idx == THT_EN_IDX) begin
				dat_next[2:0] = en_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg  <= THT_STAT_RST;
			en_reg      <= THT_EN_RST;
			trip_n_reg  <= 1'b1;
			full_reg    <= '0;
			ack_reg     <= 1'b0;
			dat_reg     <= '0;
			pg_prev_reg <= 1'b0;
		end else if (ce_i) begin
			status_reg  <= status_next;
			en_reg      <= en_next;
			trip_n_reg  <= trip_n_next;
			full_reg    <= full_next;
			ack_reg     <= ack_next;
			dat_reg     <= dat_next;
			pg_prev_reg <= pg_lvl;
		end
	end

	assign wb_ack_o              = ack_reg;
	assign wb_dat_o              = dat_reg;
	assign pwm_full_o            = full_reg;
	assign shutdown_trip_out_n_o = trip_n_reg;

	property p_lock_holds;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && lock_i) |=> $stable({abs_reg, trip_lim_reg, en_reg});
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked register changed on write");

	property p_override_full;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && auto_fan_i && |ovr_zone) |=> (pwm_full_o == ~$past(pwm_disable_i));
	endproperty
	a_override_full: assert property (p_override_full) else $error("override did not force PWMs");

	property p_override_off;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && abs_reg[0] == THT_ABS_OFF && abs_reg[1] == THT_ABS_OFF && abs_reg[2] == THT_ABS_OFF)
			|=> (pwm_full_o == '0);
	endproperty
	a_override_off: assert property (p_override_off) else $error("disabled override forced PWMs");

	property p_two_cycles;
		@(posedge clk_i) disable iff (rst_i)
		$rose(trip_event[0]) |-> ($past(cnt_reg[0]) == THT_TRIP_CYCLES - 2'h1) && $past(cycle_strobe_i);
	endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("trip event without two cycles");

	property p_event_sets;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |trip_event) |=> ((status_reg & $past(trip_event)) == $past(trip_event));
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("trip event did not set status");

	property p_pin_enable;
		@(posedge clk_i) disable iff (rst_i)
		!shutdown_trip_out_n_o |-> $past(|(trip_event & en_reg));
	endproperty
	a_pin_enable: assert property (p_pin_enable) else $error("trip pin low without enabled event");

	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && status_reg[0] && !clr_req[0] && !pg_rise) |=> status_reg[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

	property p_pg_clear;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && pg_rise && trip_event == '0) |=> (status_reg == THT_STAT_RST);
	endproperty
	a_pg_clear: assert property (p_pg_clear) else $error("power-good rise did not clear status");

	property p_equal_safe;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && cycle_strobe_i && temp[0] == trip_lim_reg[0]) |=> (cnt_reg[0] == '0);
	endproperty
	a_equal_safe: assert property (p_equal_safe) else $error("equal reading counted as exceed");

	property p_clear_refused;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |(clr_req & trip_event))
			|=> ((status_reg & $past(clr_req & trip_event)) == $past(clr_req & trip_event));
	endproperty
	a_clear_refused: assert property (p_clear_refused) else $error("status cleared during live event");

	property p_clear_done;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && clr_req[0] && !trip_event[0]) |=> !status_reg[0];
	endproperty
	a_clear_done: assert property (p_clear_done) else $error("write-one clear did not clear status");

	property p_pin_follows;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |(trip_event & en_reg)) |=> !shutdown_trip_out_n_o;
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("enabled event left trip pin high");

	property p_full_disabled;
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> ((pwm_full_o & $past(pwm_disable_i)) == '0);
	endproperty
	a_full_disabled: assert property (p_full_disabled) else $error("disabled PWM was forced full");

	property p_manual_off;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !auto_fan_i) |=> (pwm_full_o == '0);
	endproperty
	a_manual_off: assert property (p_manual_off) else $error("override active without auto fan mode");

	property p_count_hold;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !cycle_strobe_i) |=> $stable(cnt_reg);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("trip count moved without a cycle strobe");

endmodule // thtrip_top

// file: verif/thtrip_fan_model.sv
/*
 * Model of the fans and the shutdown circuitry behind the trip pin.
 * Assumes the force lines and the active-low trip pin are levels on the system clock.
 */
`timescale 1ns/1ps

module thtrip_fan_model #(
	parameter int NUM_PWM = 3
) (
	input  wire logic               clk_i,      // System clock.
	input  wire logic               rst_i,      // Synchronous reset.
	input  wire logic [NUM_PWM-1:0] pwm_full_i, // Force 100% duty.
	input  wire logic               trip_n_i,   // Shutdown request, active low.
	output logic      [NUM_PWM-1:0] at_full_o,  // Fan running at full duty.
	output logic                    shut_o      // Shutdown latched.
);
	// The supply stays off once tripped, as a real controller would hold it until reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			at_full_o <= '0;
			shut_o    <= 1'b0;
		end else begin
			at_full_o <= pwm_full_i;
			if (!trip_n_i) shut_o <= 1'b1;
		end
	end
endmodule // thtrip_fan_model

// file: verif/testbench.sv
/*
 * Self-checking bench for the thermal limit and trip logic.
 * Assumes the design package is compiled first and the fan model beside it.
 */
`timescale 1ns/1ps

module testbench;
	import thtrip_pkg::*;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, strobe = 0, lock = 0, auto_fan = 0, pg = 1;
	logic [9:0]  adr = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic        ack, trip_n, shut;
	logic [7:0]  ambient = '0, diode1 = '0, diode2 = '0;
	logic        ce = 1;
	logic [2:0]  dis = '0, full, at_full;
	int          miscompares = 0, n_checks = 0;
	logic [15:0] rows [9] = '{16'h6A64, 16'h6B64, 16'h6C64, 16'hC47F, 16'hC57F, 16'hC97F,
		16'hCA00, 16'hCB00, 16'h0400};

	always #20 clk = ~clk;

	thtrip_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ambient_temp_i(ambient), .diode1_temp_i(diode1), .diode2_temp_i(diode2), .cycle_strobe_i(strobe),
		.lock_i(lock), .auto_fan_i(auto_fan), .pwm_disable_i(dis), .supply_power_good_i(pg), .pwm_full_o(full),
		.shutdown_trip_out_n_o(trip_n));
	thtrip_fan_model fan (.clk_i(clk), .rst_i(rst), .pwm_full_i(full), .trip_n_i(trip_n),
		.at_full_o(at_full), .shut_o(shut));

	task finish_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		if (n >= 20) chk(32'h1, 32'h0);
	endtask

	task rd_chk(input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		chk(q, {24'h0, e});
	endtask

	task pulse;
		@(posedge clk);
		strobe <= 1'b1;
		@(posedge clk);
		strobe <= 1'b0;
	endtask

	initial begin
		tick(2);
		rst <= 1'b0;
		foreach (rows[i]) rd_chk(rows[i][15:8], rows[i][7:0]);
		auto_fan <= 1'b1; dis <= 3'b010; ambient <= 8'h64;
		tick(3); chk(full, 3'h0);
		ambient <= 8'h65;
		tick(3); chk(full, 3'h5);
		chk(at_full, 3'h5);
		auto_fan <= 1'b0;
		tick(3); chk(full, 3'h0);
		auto_fan <= 1'b1;
		wb(1'b1, 8'h6B, 8'h80); ambient <= 8'h7F;
		tick(3); chk(full, 3'h0);
		wb(1'b1, 8'h6C, 8'h7F); diode2 <= 8'h7F;
		tick(3); chk(full, 3'h0);
		wb(1'b1, 8'h6A, 8'hCE); diode1 <= 8'hCD;
		tick(3); chk(full, 3'h0);
		diode1 <= 8'hFF;
		tick(3); chk(full, 3'h5);
		diode1 <= 8'h00; diode2 <= 8'h33; ambient <= 8'h11;
		wb(1'b1, 8'hC5, 8'h32); wb(1'b1, 8'hC9, 8'h10); wb(1'b1, 8'hCB, 8'h04);
		rd_chk(8'hC5, 8'h32);
		pulse; tick(3); rd_chk(8'hCA, 8'h00);
		chk(trip_n, 1'b1);
		pulse; tick(3); rd_chk(8'hCA, 8'h05);
		chk(trip_n, 1'b0);
		chk(shut, 1'b1);
		wb(1'b1, 8'hCB, 8'h00);
		tick(3); chk(trip_n, 1'b1);
		wb(1'b1, 8'hCB, 8'h04);
		wb(1'b1, 8'hCA, 8'h07); rd_chk(8'hCA, 8'h05);
		diode2 <= 8'h00; ambient <= 8'h00;
		pulse; tick(3); chk(trip_n, 1'b1);
		rd_chk(8'hCA, 8'h05);
		wb(1'b1, 8'hCA, 8'h01); rd_chk(8'hCA, 8'h04);
		pg <= 1'b0; tick(6);
		pg <= 1'b1; tick(10);
		rd_chk(8'hCA, 8'h00);
		// A reading equal to the trip limit never counts, however many cycles it lasts.
		ambient <= 8'h10;
		pulse; pulse; tick(3); rd_chk(8'hCA, 8'h00);
		// Strobes seen while the clock enable is low must not count as monitoring cycles.
		ce <= 1'b0; ambient <= 8'h7F;
		pulse; pulse; ce <= 1'b1;
		tick(3); rd_chk(8'hCA, 8'h00);
		// With every absolute limit at 80h even the hottest readings leave the fans alone.
		wb(1'b1, 8'h6A, 8'h80); wb(1'b1, 8'h6C, 8'h80); diode1 <= 8'h7F; diode2 <= 8'h7F;
		tick(3); chk(full, 3'h0);
		lock <= 1'b1;
		wb(1'b1, 8'h6A, 8'h00); wb(1'b1, 8'hC4, 8'h00); wb(1'b1, 8'hCB, 8'h07);
		rd_chk(8'h6A, 8'h80);
		rd_chk(8'hC4, 8'h7F);
		rd_chk(8'hCB, 8'h04);
		finish_test;
	end

	// About 36 bus cycles of three clocks each plus waits; this leaves a wide margin.
	initial begin
		tick(5000);
		miscompares++;
		finish_test;
	end
endmodule // testbench
